/* File: hdl/irsp_top.sv */
// two-wire register slave port: link-side protocol engine and core register access
`timescale 1ns/10ps

module irsp_top
  import irsp_pkg::*;
(
  // core clock domain
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic core_ce,
  // link sampling clock domain
  input wire logic link_clk,
  // bus pins, clock is input only
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // three-level straps from the pad comparators
  input wire logic [1:0] strap_select_upper,
  input wire logic [1:0] strap_select_lower,
  output logic four_wire_sel,
  // register access toward the register bank
  output logic reg_wr,
  output logic reg_rd,
  output logic [PTR_W-1:0] reg_addr,
  output logic [BYTE_W-1:0] reg_wdata,
  input wire logic [BYTE_W-1:0] reg_rdata
);

  //////////////////////////////////////////////////////////////////////////////
  // link-domain reset, taken from the core reset through two flops
  logic lrst_m_q; // first stage
  logic lrst_n_q; // link reset, active low

  always_ff @(posedge link_clk) begin
    lrst_m_q <= resetn;
    lrst_n_q <= lrst_m_q;
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; only the second stage and later are looked at
  logic scl_m_q, scl_s_q, scl_p_q; // clock line stages
  logic sda_m_q, sda_s_q, sda_p_q; // data line stages
  logic [1:0] up_m_q, up_s_q; // upper strap stages
  logic [1:0] lo_m_q, lo_s_q; // lower strap stages

  always_ff @(posedge link_clk) begin
    if (!lrst_n_q) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      up_m_q <= LVL_LOW;
      up_s_q <= LVL_LOW;
      lo_m_q <= LVL_LOW;
      lo_s_q <= LVL_LOW;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      up_m_q <= strap_select_upper;
      up_s_q <= up_m_q;
      lo_m_q <= strap_select_lower;
      lo_s_q <= lo_m_q;
    end
  end

  // bus events, sampled far faster than the fast rate
  wire logic scl_rise = scl_s_q & ~scl_p_q;
  wire logic scl_fall = ~scl_s_q & scl_p_q;
  wire logic scl_high = scl_s_q & scl_p_q;
  wire logic start_det = scl_high & sda_p_q & ~sda_s_q;
  wire logic stop_det = scl_high & ~sda_p_q & sda_s_q;

  //////////////////////////////////////////////////////////////////////////////
  // strap decoding
  logic [SLV_ADDR_W-1:0] slave_addr; // decoded own address
  logic four_wire_q; // four-wire port selected

  irsp_strap_decode u_strap (
    .link_clk (link_clk),
    .rst_n (lrst_n_q),
    .strap_up (up_s_q),
    .strap_lo (lo_s_q),
    .slave_addr_q (slave_addr),
    .four_wire_q (four_wire_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // protocol engine state
  irsp_state_t state_q; // engine state
  logic [2:0] bit_cnt_q; // bit within byte
  logic [1:0] byte_cnt_q; // byte within write, saturating
  logic [BYTE_W-1:0] rx_q; // receive shifter
  logic [BYTE_W-1:0] tx_q; // transmit shifter
  logic [BYTE_W-1:0] ptr_hi_q; // pending pointer high byte
  logic [PTR_W-1:0] ptr_q; // register pointer, kept across transactions
  logic rd_q; // current transaction reads
  logic sda_oe_n_q; // low drives the data line low
  logic [BYTE_W-1:0] rbuf_q; // read byte returned from the core

  // decode of the byte just completing
  wire logic [BYTE_W-1:0] rx_next = {rx_q[BYTE_W-2:0], sda_s_q};
  wire logic [PTR_W-1:0] ptr_word = {ptr_hi_q, rx_next};
  wire logic byte_done = (state_q == ST_RX) && scl_rise && (bit_cnt_q == BIT_LAST);
  wire logic addr_byte = byte_done && (byte_cnt_q == BYTE_ADDR);
  wire logic addr_hit = (rx_next[BYTE_W-1:1] == slave_addr) && !four_wire_q;
  wire logic data_wr = byte_done && (byte_cnt_q == BYTE_DATA);
  wire logic master_ack = (state_q == ST_MACK) && scl_rise && !sda_s_q;
  wire logic master_nack = (state_q == ST_MACK) && scl_rise && sda_s_q;
  wire logic rd_issue = (addr_byte && addr_hit && rx_next[0] == DIR_READ) || master_ack;

  // protocol engine; start and stop override every bit position
  always_ff @(posedge link_clk) begin
    if (!lrst_n_q) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= BYTE_ADDR;
      rx_q <= BYTE_RST;
      tx_q <= BYTE_RST;
      ptr_hi_q <= BYTE_RST;
      ptr_q <= PTR_RST;
      rd_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else if (start_det) begin
      // start or repeated start: drop any partial byte
      state_q <= ST_RX;
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= BYTE_ADDR;
      sda_oe_n_q <= 1'b1;
    end else if (stop_det) begin
      // stop: back to idle, pointer kept
      state_q <= ST_IDLE;
      sda_oe_n_q <= 1'b1;
    end else begin
      case (state_q)
        ST_RX: begin
          if (scl_rise) begin
            rx_q <= rx_next;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == BIT_LAST) begin
              // unmatched address: ignore everything until a start
              state_q <= (byte_cnt_q == BYTE_ADDR && !addr_hit) ? ST_IDLE : ST_AHOLD;
              if (byte_cnt_q != BYTE_DATA) begin
                byte_cnt_q <= byte_cnt_q + 2'h1;
              end
              case (byte_cnt_q)
                BYTE_ADDR: rd_q <= rx_next[0];
                BYTE_PTR_HI: ptr_hi_q <= rx_next;
                BYTE_PTR_LO: ptr_q <= ptr_word;
                default: ptr_q <= ptr_q + 16'h0001;
              endcase
            end
          end
        end
        ST_AHOLD: begin
          // drive ack only once the clock is low
          if (scl_fall) begin
            sda_oe_n_q <= 1'b0;
            state_q <= ST_ACK;
          end
        end
        ST_ACK: begin
          // end of ninth slot: release, or put out the first read bit
          if (scl_fall) begin
            bit_cnt_q <= 3'h0;
            if (rd_q) begin
              tx_q <= rbuf_q;
              sda_oe_n_q <= rbuf_q[BYTE_W-1];
              ptr_q <= ptr_q + 16'h0001;
              state_q <= ST_TX;
            end else begin
              sda_oe_n_q <= 1'b1;
              state_q <= ST_RX;
            end
          end
        end
        ST_TX: begin
          // msb first, next bit put out on each falling clock
          if (scl_fall) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == BIT_LAST) begin
              sda_oe_n_q <= 1'b1; // master owns the ack slot
              state_q <= ST_MACK;
            end else begin
              tx_q <= {tx_q[BYTE_W-2:0], 1'b1};
              sda_oe_n_q <= tx_q[BYTE_W-2];
            end
          end
        end
        ST_MACK: begin
          // master ack: next byte; nack: read over, line stays free
          if (master_nack) begin
            state_q <= ST_IDLE;
          end else if (master_ack) begin
            state_q <= ST_ACK;
          end
        end
        default: begin
          state_q <= ST_IDLE; // idle waits for a start
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // request toward the core: toggle plus fields held steady until the next one
  logic req_tgl_q; // flips once per request
  logic req_we_q; // request is a write
  logic [PTR_W-1:0] req_addr_q; // register address
  logic [BYTE_W-1:0] req_wdata_q; // write data

  always_ff @(posedge link_clk) begin
    if (!lrst_n_q) begin
      req_tgl_q <= 1'b0;
      req_we_q <= 1'b0;
      req_addr_q <= PTR_RST;
      req_wdata_q <= BYTE_RST;
    end else if (!start_det && !stop_det && (data_wr || rd_issue)) begin
      req_tgl_q <= ~req_tgl_q;
      req_we_q <= data_wr;
      req_addr_q <= ptr_q;
      req_wdata_q <= rx_next;
    end
  end

  // answer from the core, caught into the read buffer
  logic ack_m_q, ack_s_q, ack_p_q; // answer toggle stages
  logic ack_tgl_q; // core side answer toggle
  logic [BYTE_W-1:0] rdata_q; // core side read data, steady after the toggle

  always_ff @(posedge link_clk) begin
    if (!lrst_n_q) begin
      ack_m_q <= 1'b0;
      ack_s_q <= 1'b0;
      ack_p_q <= 1'b0;
      rbuf_q <= BYTE_RST;
    end else begin
      ack_m_q <= ack_tgl_q;
      ack_s_q <= ack_m_q;
      ack_p_q <= ack_s_q;
      if (ack_s_q != ack_p_q) begin
        rbuf_q <= rdata_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // core side: request toggle synchroniser and register strobes
  logic req_m_q, req_s_q, req_p_q; // request toggle stages
  logic reg_wr_q, reg_rd_q; // one-cycle strobes
  logic [PTR_W-1:0] reg_addr_q; // held address
  logic [BYTE_W-1:0] reg_wdata_q; // held write data
  wire logic req_edge = req_s_q ^ req_p_q;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      req_m_q <= 1'b0;
      req_s_q <= 1'b0;
      req_p_q <= 1'b0;
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      reg_addr_q <= PTR_RST;
      reg_wdata_q <= BYTE_RST;
      rdata_q <= BYTE_RST;
      ack_tgl_q <= 1'b0;
    end else if (core_ce) begin
      req_m_q <= req_tgl_q;
      req_s_q <= req_m_q;
      req_p_q <= req_s_q;
      reg_wr_q <= req_edge & req_we_q;
      reg_rd_q <= req_edge & ~req_we_q;
      if (req_edge) begin
        reg_addr_q <= req_addr_q;
        reg_wdata_q <= req_wdata_q;
      end
      if (reg_rd_q) begin
        rdata_q <= reg_rdata; // bank answers during the strobe
      end
      ack_tgl_q <= ack_tgl_q ^ (reg_wr_q | reg_rd_q);
    end
  end

  // outputs straight from flops; data pin only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_n = sda_oe_n_q;
  assign four_wire_sel = four_wire_q;
  assign reg_wr = reg_wr_q;
  assign reg_rd = reg_rd_q;
  assign reg_addr = reg_addr_q;
  assign reg_wdata = reg_wdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  hold_while_high_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
    $changed(sda_oe_n_q) |-> !scl_s_q)
    else $error("data line moved while clock high");

  ack_drive_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
    (state_q == ST_AHOLD && scl_fall && !start_det && !stop_det)
      |=> (state_q == ST_ACK && !sda_oe_n_q))
    else $error("ack not driven low");

  addr_miss_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
    (addr_byte && !addr_hit && !start_det && !stop_det)
      |=> (state_q == ST_IDLE && sda_oe_n_q) [*2])
    else $error("unmatched address answered");

  restart_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
    start_det |=> (state_q == ST_RX && bit_cnt_q == 3'h0 && byte_cnt_q == BYTE_ADDR))
    else $error("start did not restart address");

  stop_idle_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
    (stop_det && !start_det) |=> (state_q == ST_IDLE && sda_oe_n_q))
    else $error("stop did not release");

  nack_release_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
    (master_nack && !start_det && !stop_det) |=> (state_q == ST_IDLE && sda_oe_n_q))
    else $error("nack did not end read");

  ptr_load_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
    (byte_done && byte_cnt_q == BYTE_PTR_LO && !start_det && !stop_det)
      |=> (ptr_q == $past(ptr_word)))
    else $error("pointer not loaded high byte first");

  ptr_step_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
    (data_wr && !start_det && !stop_det)
      |=> (ptr_q == $past(ptr_q) + 16'h0001 && req_we_q && req_addr_q == $past(ptr_q)))
    else $error("write pointer did not advance");

  spi_quiet_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
    four_wire_q |-> ##1 (state_q != ST_AHOLD))
    else $error("two-wire port answered in four-wire mode");

  wr_strobe_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (core_ce && req_edge && req_we_q) |=> (reg_wr_q && !reg_rd_q && reg_addr_q == $past(req_addr_q)))
    else $error("write strobe missing");

endmodule : irsp_top

/* File: hdl/irsp_pkg.sv */
// constants and types shared by the two-wire register slave port
package irsp_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // slave address layout
  localparam logic [3:0] SLV_ADDR_UPPER = 4'hb; // fixed upper four address bits
  localparam int SLV_ADDR_W = 7; // seven-bit slave address
  localparam int SLV_LOW_W = 3; // strap-selected low address bits
  localparam logic [3:0] LVL_WEIGHT = 4'h3; // weight of the upper strap level

  // three-level strap encoding from the pad comparators
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_OPEN = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;

  //////////////////////////////////////////////////////////////////////////////
  // byte framing
  localparam int BYTE_W = 8; // bits per byte on the wire
  localparam int PTR_W = 16; // register pointer width
  localparam logic [2:0] BIT_LAST = 3'h7; // index of the eighth bit
  localparam logic [1:0] BYTE_ADDR = 2'h0; // slave address byte
  localparam logic [1:0] BYTE_PTR_HI = 2'h1; // pointer high byte
  localparam logic [1:0] BYTE_PTR_LO = 2'h2; // pointer low byte
  localparam logic [1:0] BYTE_DATA = 2'h3; // register data, saturates here
  localparam logic DIR_READ = 1'b1; // direction bit value for a read

  // reset values
  localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // timing: bus rates and the oversampling the link clock must provide
  localparam int SCL_STD_KHZ = 100; // standard rate
  localparam int SCL_FAST_KHZ = 400; // fast rate
  localparam int CORE_CLK_KHZ = 125000; // core clock rate
  localparam int LINK_MIN_SAMPLES = 16; // link samples per bus bit, least
  localparam int LINK_MIN_KHZ = SCL_FAST_KHZ * LINK_MIN_SAMPLES; // least link rate
  localparam int CORE_PER_STD_BIT = CORE_CLK_KHZ / SCL_STD_KHZ; // core cycles, std bit
  localparam int CORE_PER_FAST_BIT = CORE_CLK_KHZ / SCL_FAST_KHZ; // core cycles, fast bit

  // link-side protocol states
  typedef enum logic [2:0] {
    ST_IDLE,  // not addressed, bus released
    ST_RX,    // shifting a byte in
    ST_AHOLD, // byte taken, waiting for low phase to ack
    ST_ACK,   // ninth slot, ack driven or read byte pending
    ST_TX,    // shifting a byte out
    ST_MACK   // waiting for the master's ack of a read byte
  } irsp_state_t;

endpackage : irsp_pkg

/* File: hdl/irsp_strap_decode.sv */
// strap decoder: two three-level straps to slave address or four-wire select
`timescale 1ns/10ps

module irsp_strap_decode
  import irsp_pkg::*;
(
  // clock and reset
  input wire logic link_clk,
  input wire logic rst_n,
  // synchronised strap levels
  input wire logic [1:0] strap_up,
  input wire logic [1:0] strap_lo,
  // decoded result
  output logic [SLV_ADDR_W-1:0] slave_addr_q,
  output logic four_wire_q
);

  //////////////////////////////////////////////////////////////////////////////
  // level to number, used for both straps
  function automatic logic [3:0] lvl_num(input logic [1:0] lvl);
    logic [3:0] n;
    n = 4'h0;
    case (lvl)
      LVL_OPEN: n = 4'h1;
      LVL_HIGH: n = 4'h2;
      default: n = 4'h0; // low, or an unused code
    endcase
    return n;
  endfunction : lvl_num

  // combination index 0..8, eight picks the four-wire port
  wire logic [3:0] combo = 4'((lvl_num(strap_up) * LVL_WEIGHT) + lvl_num(strap_lo));
  wire logic both_high = (strap_up == LVL_HIGH) && (strap_lo == LVL_HIGH);

  // caught on the clock, so the straps may settle after reset
  always_ff @(posedge link_clk) begin
    if (!rst_n) begin
      slave_addr_q <= {SLV_ADDR_UPPER, 3'h0};
      four_wire_q <= 1'b0;
    end else begin
      slave_addr_q <= {SLV_ADDR_UPPER, combo[SLV_LOW_W-1:0]};
      four_wire_q <= both_high;
    end
  end

  // both straps high selects the four-wire port
  spi_select_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    (strap_up == LVL_HIGH && strap_lo == LVL_HIGH) |=> four_wire_q)
    else $error("four-wire select missed");

  // upper bits fixed, low bits follow the strap combination
  addr_decode_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    !both_high |=> (slave_addr_q[6:3] == SLV_ADDR_UPPER)
      && (slave_addr_q[2:0] == $past(combo[2:0])) && !four_wire_q)
    else $error("slave address decode wrong");

endmodule : irsp_strap_decode

/* File: sim/irsp_bus_master.sv */
// behavioural two-wire bus master driving the slave port
`timescale 1ns/10ps

module irsp_bus_master (
  // bus side, data line is open drain and pulled up outside
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  int q_ns = 625; // quarter bit period, fast rate

  // bus idle: both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // start, also used as repeated start
  task start;
    sda_low = 1'b0;
    #q_ns;
    scl = 1'b1;
    #q_ns;
    sda_low = 1'b1;
    #q_ns;
    scl = 1'b0;
    #q_ns;
  endtask : start

  // stop after the last slot
  task stop;
    sda_low = 1'b1;
    #q_ns;
    scl = 1'b1;
    #q_ns;
    sda_low = 1'b0;
    #q_ns;
  endtask : stop

  // n bits msb first, then the ack slot if the byte is whole
  task send(input logic [7:0] b, input int n, output logic ack);
    for (int i = 0; i < n; i++) begin
      sda_low = ~b[7-i]; // changed only while clock low
      #q_ns;
      scl = 1'b1;
      #(2*q_ns);
      scl = 1'b0;
      #q_ns;
    end
    ack = 1'b0;
    if (n == 8) begin
      sda_low = 1'b0;
      #q_ns;
      scl = 1'b1;
      #q_ns;
      ack = (sda === 1'b0);
      #q_ns;
      scl = 1'b0;
      #q_ns;
    end
  endtask : send

  // read a byte, then ack or leave high for the last one
  task recv(output logic [7:0] b, input logic last);
    sda_low = 1'b0;
    for (int i = 0; i < 8; i++) begin
      #q_ns;
      scl = 1'b1;
      #q_ns;
      b[7-i] = sda;
      #q_ns;
      scl = 1'b0;
      #q_ns;
    end
    sda_low = ~last;
    #q_ns;
    scl = 1'b1;
    #(2*q_ns);
    scl = 1'b0;
    #q_ns;
  endtask : recv
endmodule : irsp_bus_master

/* File: sim/testbench.sv */
// self-checking bench for the two-wire register slave port
`timescale 1ns/10ps

module testbench;
  import irsp_pkg::*;
  logic core_clk, link_clk, resetn, scl, sda, m_low, sda_o, sda_oe_n, four_wire_sel;
  logic [1:0] su, sl;
  logic reg_wr, reg_rd;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [7:0] mem [256]; // register bank model
  logic [7:0] exp_mem [256]; // expected bank contents
  logic [23:0] wlog [$]; // observed writes
  logic [6:0] dev = 7'h5c; // address with both straps open
  int errors = 0;
  int total_checks = 0;

  // wired-and data line with pull-up
  assign sda = (m_low | ~sda_oe_n) ? 1'b0 : 1'b1;
  assign reg_rdata = mem[reg_addr[7:0]];

  irsp_top i_irsp_top (.core_clk(core_clk), .resetn(resetn), .core_ce(1'b1),
    .link_clk(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .strap_select_upper(su), .strap_select_lower(sl), .four_wire_sel(four_wire_sel),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  irsp_bus_master i_irsp_bus_master (.scl(scl), .sda_low(m_low), .sda(sda));

  ////////////////////////////////////////////////////////////////////////////////
  // clocks, unrelated phases
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  // bank writes logged for comparison
  always @(posedge core_clk) begin
    if (reg_wr === 1'b1) begin
      mem[reg_addr[7:0]] <= reg_wdata;
      wlog.push_back({reg_addr, reg_wdata});
    end
  end

  // data line must not move under a high clock
  always @(sda_oe_n) if (scl === 1'b1 && resetn === 1'b1) fail("sda moved, scl high");

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  task fail(input string m);
    errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : fail

  task chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) fail(m);
  endtask : chk

  // long enough for both domains
  task do_reset;
    @(posedge core_clk);
    #1 resetn = 1'b0;
    repeat (32) @(posedge core_clk);
    #1 resetn = 1'b1;
    repeat (150) @(posedge core_clk);
  endtask : do_reset

  // start, address for write, two pointer bytes
  task set_ptr(input logic [15:0] p);
    logic a0, a1, a2;
    i_irsp_bus_master.start();
    i_irsp_bus_master.send({dev, 1'b0}, 8, a0);
    i_irsp_bus_master.send(p[15:8], 8, a1);
    i_irsp_bus_master.send(p[7:0], 8, a2);
    chk(a0 & a1 & a2, "pointer bytes not acked");
  endtask : set_ptr

  // address for read, then n bytes from p, last one left unacked
  task rd(input int n, input logic [15:0] p);
    logic a;
    logic [7:0] b;
    i_irsp_bus_master.send({dev, 1'b1}, 8, a);
    chk(a, "read address not acked");
    for (int i = 0; i < n; i++) begin
      i_irsp_bus_master.recv(b, i == n - 1);
      chk(b === exp_mem[8'(p + 16'(i))], "read data");
    end
    chk(sda_oe_n === 1'b1 && sda_o === 1'b0, "data line held after nack");
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task t_straps;
    logic a;
    logic [1:0] lv [3];
    lv = '{LVL_LOW, LVL_OPEN, LVL_HIGH};
    for (int u = 0; u < 3; u++) begin
      for (int l = 0; l < 3; l++) begin
        su = lv[u];
        sl = lv[l];
        do_reset();
        i_irsp_bus_master.start();
        // both high aliases the low-low address, so silence is really tested
        i_irsp_bus_master.send({SLV_ADDR_UPPER, 3'(u * 3 + l), 1'b0}, 8, a);
        i_irsp_bus_master.stop();
        chk(a === (u * 3 + l != 8), "strap address ack");
        chk(four_wire_sel === (u * 3 + l == 8), "four-wire select");
      end
    end
    su = LVL_OPEN;
    sl = LVL_OPEN;
    do_reset();
    $display("test straps done");
  endtask : t_straps

  task t_std;
    logic a;
    i_irsp_bus_master.q_ns = 2500;
    i_irsp_bus_master.start();
    i_irsp_bus_master.send({dev, 1'b0}, 8, a);
    i_irsp_bus_master.stop();
    chk(a, "no ack at standard rate");
    i_irsp_bus_master.q_ns = 625;
    $display("test standard rate done");
  endtask : t_std

  task t_write;
    logic a0, a1;
    wlog.delete();
    set_ptr(16'h12ff);
    i_irsp_bus_master.send(8'ha5, 8, a0);
    i_irsp_bus_master.send(8'h3c, 8, a1);
    i_irsp_bus_master.stop();
    exp_mem[8'hff] = 8'ha5;
    exp_mem[8'h00] = 8'h3c;
    chk(a0 & a1, "data not acked");
    chk(wlog.size() == 2, "write count");
    chk(wlog[0] === 24'h12ff_a5 && wlog[1] === 24'h1300_3c, "write order");
    $display("test write done");
  endtask : t_write

  task t_ptr_read;
    wlog.delete();
    set_ptr(16'h0040);
    i_irsp_bus_master.stop();
    chk(wlog.size() == 0, "pointer-only write stored");
    i_irsp_bus_master.start();
    rd(2, 16'h0040);
    i_irsp_bus_master.stop();
    set_ptr(16'h12ff);
    i_irsp_bus_master.start();
    rd(2, 16'h12ff);
    i_irsp_bus_master.stop();
    $display("test reads done");
  endtask : t_ptr_read

  task t_abort;
    logic a;
    i_irsp_bus_master.start();
    i_irsp_bus_master.send({dev, 1'b0}, 8, a);
    i_irsp_bus_master.send(8'h00, 4, a);
    i_irsp_bus_master.stop();
    i_irsp_bus_master.start();
    rd(1, 16'h1301);
    i_irsp_bus_master.stop();
    $display("test abort done");
  endtask : t_abort

  task t_foreign;
    logic a0, a1;
    wlog.delete();
    i_irsp_bus_master.start();
    i_irsp_bus_master.send({dev ^ 7'h01, 1'b0}, 8, a0);
    i_irsp_bus_master.send(8'h00, 8, a1);
    i_irsp_bus_master.stop();
    chk(!a0 && !a1, "foreign address acked");
    chk(wlog.size() == 0, "foreign write stored");
    $display("test foreign address done");
  endtask : t_foreign

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and run
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  initial begin
    // the scenarios take about 0.9 ms of bus time
    #1_000_000;
    fail("timeout");
    end_of_test();
  end

  initial begin
    resetn = 1'b0;
    su = LVL_OPEN;
    sl = LVL_OPEN;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5c;
      exp_mem[i] = 8'(i) ^ 8'h5c;
    end
    t_straps();
    t_std();
    t_write();
    t_ptr_read();
    t_abort();
    t_foreign();
    end_of_test();
  end
endmodule : testbench
